// >>> logic/acmc_top.sv
// Purpose: conversion mode control of a sigma-delta converter
// Assumes: 250 MHz core clock, APB slave, serial host on SCLK/DOUT pin
// Notes:   filter arithmetic is a stand-in counter; results are counts
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "acmc_params.svh"
module acmc_top
#(
   parameter int WAKE_CYCLES = (`ACMC_CLK_SETTLE_NS
                                / `ACMC_CLK_PERIOD_NS),
   parameter int DATA_W      = `ACMC_DATA_BITS
)
(
   input  wire logic        CORE_CLK_IN,
   input  wire logic        RSTN_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   input  wire logic        SCLK_IN,
   output logic             DOUT_RDYN_OUT,
   output logic             IRQ_OUT
);
   localparam int TCW = 32;

   initial
   begin
      if (WAKE_CYCLES < 1 || DATA_W < 2 || DATA_W > 32)
         $error("unsupported parameter value");
   end

   ////////////////////////////////////////////////////////////////////
   // modulator enable and serial clock synchroniser

   acmc_tick_if tick_bus ();

   acmc_div #(.DIV(`ACMC_MOD_DIV)) u_div
   (
      .clk   (CORE_CLK_IN),
      .rst_n (RSTN_IN),
      .tick  (tick_bus.src)
   );

   logic sclk_s1_reg;
   logic sclk_s2_reg;
   logic sclk_s3_reg;
   logic sclk_fall;

   // s1 feeds only s2; edges are seen on s2 against s3
   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         sclk_s1_reg <= 1'b1;
         sclk_s2_reg <= 1'b1;
         sclk_s3_reg <= 1'b1;
      end
      else
      begin
         sclk_s1_reg <= SCLK_IN;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_s3_reg <= sclk_s2_reg;
      end
   end
   assign sclk_fall = sclk_s3_reg & ~sclk_s2_reg;

   ////////////////////////////////////////////////////////////////////
   // registers

   logic [2:0]        mode_reg;
   logic [2:0]        mode_next;
   logic              continuous_readout_enable_reg;
   logic              continuous_readout_enable_next;
   logic [2:0]        order_reg;
   logic [2:0]        order_next;
   logic [9:0]        rate_reg;
   logic [9:0]        rate_next;
   logic [DATA_W-1:0] data_reg;
   logic [DATA_W-1:0] data_next;
   logic              rdy_n_reg;
   logic              rdy_n_next;
   logic [1:0]        irq_stat_reg;
   logic [1:0]        irq_stat_next;
   logic [1:0]        irq_mask_reg;
   logic [1:0]        irq_mask_next;
   logic [31:0]       prdata_reg;
   logic [31:0]       prdata_next;

   logic wr_acc;
   logic rd_acc;
   logic addr_ok;
   logic reconfig;
   logic read_req;
   logic data_read;

   assign wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN;
   assign rd_acc = PSEL_IN & PENABLE_IN & ~PWRITE_IN;

   always_comb
   begin
      if (PADDR_IN == `ACMC_ADDR_CTRL)
         addr_ok = 1'b1;
      else if (PADDR_IN == `ACMC_ADDR_RATE)
         addr_ok = 1'b1;
      else if (PADDR_IN == `ACMC_ADDR_STATUS)
         addr_ok = 1'b1;
      else if (PADDR_IN == `ACMC_ADDR_DATA)
         addr_ok = 1'b1;
      else if (PADDR_IN == `ACMC_ADDR_IRQ_STAT)
         addr_ok = 1'b1;
      else if (PADDR_IN == `ACMC_ADDR_IRQ_MASK)
         addr_ok = 1'b1;
      else if (PADDR_IN == `ACMC_ADDR_CMD)
         addr_ok = 1'b1;
      else
         addr_ok = 1'b0;
   end

   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;

   // rate code zero is unusable, so such writes are refused
   assign reconfig = wr_acc & ((PADDR_IN == `ACMC_ADDR_CTRL) |
                     ((PADDR_IN == `ACMC_ADDR_RATE) &&
                      (PWDATA_IN[9:0] != 10'h000)));
   assign read_req = wr_acc & (PADDR_IN == `ACMC_ADDR_CMD)
                     & PWDATA_IN[`ACMC_CMD_READ_BIT];

   ////////////////////////////////////////////////////////////////////
   // conversion sequencer

   acmc_pkg::acmc_state_t state_reg;
   acmc_pkg::acmc_state_t state_next;
   logic [TCW-1:0]        tcnt_reg;
   logic [TCW-1:0]        tcnt_next;
   logic [TCW-1:0]        conv_ticks;
   logic [TCW-1:0]        settle_ticks;
   logic [3:0]            settled_reg;
   logic [3:0]            settled_next;
   logic                  conv_done;
   logic                  single_done;

   always_comb
   begin
      conv_ticks   = TCW'(`ACMC_DEC_BASE) * TCW'(order_reg)
                     * TCW'(rate_reg);
      // settling spans one conversion period, the same tick count as in RUN
      settle_ticks = conv_ticks;
   end

   always_comb
   begin
      state_next   = state_reg;
      tcnt_next    = tcnt_reg;
      settled_next = settled_reg;
      conv_done    = 1'b0;
      single_done  = 1'b0;
      case (state_reg)
         acmc_pkg::ACMC_ST_IDLE:
         begin
            tcnt_next    = '0;
            settled_next = '0;
            if (mode_reg == `ACMC_MODE_CONT)
               state_next = acmc_pkg::ACMC_ST_SETTLE;
         end
         acmc_pkg::ACMC_ST_WAKE:
         begin
            if (tcnt_reg >= TCW'(WAKE_CYCLES - 1))
            begin
               tcnt_next  = '0;
               state_next = acmc_pkg::ACMC_ST_SETTLE;
            end
            else
               tcnt_next = tcnt_reg + TCW'(1);
         end
         acmc_pkg::ACMC_ST_SETTLE:
         begin
            if (tick_bus.mod_tick)
            begin
               if (tcnt_reg >= settle_ticks - TCW'(1))
               begin
                  tcnt_next    = '0;
                  conv_done    = 1'b1;
                  settled_next = 4'h1;
                  if (mode_reg == `ACMC_MODE_SINGLE)
                  begin
                     single_done = 1'b1;
                     state_next  = acmc_pkg::ACMC_ST_IDLE;
                  end
                  else
                     state_next = acmc_pkg::ACMC_ST_RUN;
               end
               else
                  tcnt_next = tcnt_reg + TCW'(1);
            end
         end
         acmc_pkg::ACMC_ST_RUN:
         begin
            if (tick_bus.mod_tick)
            begin
               if (tcnt_reg >= conv_ticks - TCW'(1))
               begin
                  tcnt_next = '0;
                  conv_done = 1'b1;
               end
               else
                  tcnt_next = tcnt_reg + TCW'(1);
            end
         end
         default:
         begin
            state_next = acmc_pkg::ACMC_ST_IDLE;
            tcnt_next  = '0;
         end
      endcase
      if (reconfig)
      begin
         tcnt_next    = '0;
         settled_next = '0;
         if (mode_next == `ACMC_MODE_CONT)
            state_next = acmc_pkg::ACMC_ST_SETTLE;
         else if (mode_next == `ACMC_MODE_SINGLE)
            state_next = acmc_pkg::ACMC_ST_WAKE;
         else
            state_next = acmc_pkg::ACMC_ST_IDLE;
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         state_reg   <= acmc_pkg::ACMC_ST_SETTLE;
         tcnt_reg    <= '0;
         settled_reg <= '0;
      end
      else
      begin
         state_reg   <= state_next;
         tcnt_reg    <= tcnt_next;
         settled_reg <= settled_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // serial output

   logic shift_busy;
   logic shift_last;
   logic shift_load;
   logic pend_reg;
   logic pend_next;

   // a result arriving mid-shift waits; the current word is not torn
   assign shift_load = ~shift_busy & ((continuous_readout_enable_reg & pend_reg) | read_req);

   acmc_shift #(.W(DATA_W)) u_shift
   (
      .clk       (CORE_CLK_IN),
      .rst_n     (RSTN_IN),
      .load      (shift_load),
      .data      (data_reg),
      .sclk_fall (sclk_fall),
      .ready_n   (rdy_n_reg),
      .dout      (DOUT_RDYN_OUT),
      .busy      (shift_busy),
      .last      (shift_last)
   );

   assign data_read = shift_last | (rd_acc & (PADDR_IN == `ACMC_ADDR_DATA));

   ////////////////////////////////////////////////////////////////////
   // register updates

   always_comb
   begin
      mode_next     = mode_reg;
      continuous_readout_enable_next    = continuous_readout_enable_reg;
      order_next    = order_reg;
      rate_next     = rate_reg;
      irq_mask_next = irq_mask_reg;
      data_next     = data_reg;
      rdy_n_next    = rdy_n_reg;
      pend_next     = pend_reg;
      irq_stat_next = irq_stat_reg;
      prdata_next   = prdata_reg;
      if (wr_acc && PADDR_IN == `ACMC_ADDR_CTRL)
      begin
         mode_next  = PWDATA_IN[`ACMC_CTRL_MODE_LSB +: 3];
         continuous_readout_enable_next = PWDATA_IN[`ACMC_CTRL_CONTINUOUS_READOUT_ENABLE_BIT];
         if (PWDATA_IN[`ACMC_CTRL_ORDER_LSB +: 3] != 3'h0)
            order_next = PWDATA_IN[`ACMC_CTRL_ORDER_LSB +: 3];
      end
      if (wr_acc && PADDR_IN == `ACMC_ADDR_RATE &&
          PWDATA_IN[9:0] != 10'h000)
         rate_next = PWDATA_IN[9:0];
      if (wr_acc && PADDR_IN == `ACMC_ADDR_IRQ_MASK)
         irq_mask_next = PWDATA_IN[1:0];
      // a reconfiguration cancels a pending shift, but a result completing in that same cycle is still shifted later
      if (shift_load || reconfig)
         pend_next = 1'b0;
      if (data_read || reconfig)
         rdy_n_next = 1'b1;
      if (rd_acc && PADDR_IN == `ACMC_ADDR_IRQ_STAT)
         irq_stat_next = 2'h0;
      if (conv_done)
      begin
         data_next  = data_reg + DATA_W'(1);
         rdy_n_next = 1'b0;
         pend_next  = 1'b1;
         irq_stat_next[`ACMC_IRQ_DONE_BIT] = 1'b1;
      end
      if (single_done)
         irq_stat_next[`ACMC_IRQ_SINGLE_BIT] = 1'b1;
      if (rd_acc)
      begin
         if (PADDR_IN == `ACMC_ADDR_CTRL)
            prdata_next = {21'h0, order_reg, 3'h0, continuous_readout_enable_reg, 1'b0, mode_reg};
         else if (PADDR_IN == `ACMC_ADDR_RATE)
            prdata_next = {22'h0, rate_reg};
         else if (PADDR_IN == `ACMC_ADDR_STATUS)
            prdata_next = {24'h0, state_reg, settled_reg[0], 2'h0,
                           rdy_n_reg};
         else if (PADDR_IN == `ACMC_ADDR_DATA)
            prdata_next = 32'(data_reg);
         else if (PADDR_IN == `ACMC_ADDR_IRQ_STAT)
            prdata_next = {30'h0, irq_stat_reg};
         else if (PADDR_IN == `ACMC_ADDR_IRQ_MASK)
            prdata_next = {30'h0, irq_mask_reg};
         else
            prdata_next = 32'h0;
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         mode_reg     <= `ACMC_MODE_CONT;
         continuous_readout_enable_reg    <= 1'b0;
         order_reg    <= `ACMC_ORDER_RESET;
         rate_reg     <= `ACMC_RATE_RESET;
         irq_mask_reg <= 2'h0;
         data_reg     <= '0;
         rdy_n_reg    <= 1'b1;
         pend_reg     <= 1'b0;
         irq_stat_reg <= 2'h0;
         prdata_reg   <= 32'h0;
      end
      else
      begin
         mode_reg     <= mode_next;
         continuous_readout_enable_reg    <= continuous_readout_enable_next;
         order_reg    <= order_next;
         rate_reg     <= rate_next;
         irq_mask_reg <= irq_mask_next;
         data_reg     <= data_next;
         rdy_n_reg    <= rdy_n_next;
         pend_reg     <= pend_next;
         irq_stat_reg <= irq_stat_next;
         prdata_reg   <= prdata_next;
      end
   end

   // read data is registered in the access cycle; PREADY still comes
   // at once, so read data is combinationally muxed for that edge
   assign PRDATA_OUT = prdata_next;
   assign IRQ_OUT    = |(irq_stat_reg & irq_mask_reg);
endmodule // acmc_top

// >>> logic/acmc_params.svh
// Purpose: named constants for the conversion mode control block
// Assumes: 250 MHz core clock, APB register access
// Notes:   offsets are byte addresses of 32-bit words
`ifndef ACMC_PARAMS_SVH
`define ACMC_PARAMS_SVH

`define ACMC_ADDR_CTRL      8'h00
`define ACMC_ADDR_RATE      8'h04
`define ACMC_ADDR_STATUS    8'h08
`define ACMC_ADDR_DATA      8'h0C
`define ACMC_ADDR_IRQ_STAT  8'h10
`define ACMC_ADDR_IRQ_MASK  8'h14
`define ACMC_ADDR_CMD       8'h18

`define ACMC_MOD_DIV        16
`define ACMC_DEC_BASE       64
`define ACMC_RATE_RESET     10'h060
`define ACMC_ORDER_RESET    3'h4
`define ACMC_MODE_CONT      3'h0
`define ACMC_MODE_SINGLE    3'h1
`define ACMC_MODE_IDLE      3'h2
`define ACMC_CLK_SETTLE_NS  1000000
`define ACMC_CLK_PERIOD_NS  4
`define ACMC_DATA_BITS      24

`define ACMC_CTRL_MODE_LSB  0
`define ACMC_CTRL_CONTINUOUS_READOUT_ENABLE_BIT 4
`define ACMC_CTRL_ORDER_LSB 8
`define ACMC_CMD_READ_BIT   0

`define ACMC_IRQ_DONE_BIT   0
`define ACMC_IRQ_SINGLE_BIT 1

`endif

// >>> logic/acmc_pkg.sv
// Purpose: shared types of the conversion mode control block
// Assumes: none
// Notes:   state codes are one-hot
package acmc_pkg;
   typedef enum logic [3:0]
   {
      ACMC_ST_IDLE   = 4'b0001,
      ACMC_ST_WAKE   = 4'b0010,
      ACMC_ST_SETTLE = 4'b0100,
      ACMC_ST_RUN    = 4'b1000
   } acmc_state_t;
endpackage

// >>> logic/acmc_tick_if.sv
// Purpose: carries the modulator tick between modules
// Assumes: single clock domain
// Notes:   pulses are one cycle wide
`timescale 1ns/1ps
interface acmc_tick_if;
   logic        mod_tick;
   modport src
   (
      output mod_tick
   );
   modport dst
   (
      input  mod_tick
   );
endinterface // acmc_tick_if

// >>> logic/acmc_div.sv
// Purpose: modulator clock enable from the core clock
// Assumes: one core clock, active low async reset
// Notes:   enable is a one-cycle pulse every DIV cycles
`timescale 1ns/1ps
`include "acmc_params.svh"
module acmc_div
#(
   parameter int DIV = `ACMC_MOD_DIV
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   acmc_tick_if.src  tick
);
   localparam int CW = $clog2(DIV);
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;

   initial
   begin
      if (DIV < 2)
         $error("divider must be at least 2");
   end

   always_comb
   begin
      if (cnt_reg == CW'(DIV - 1))
         cnt_next = '0;
      else
         cnt_next = cnt_reg + CW'(1);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end

   assign tick.mod_tick = (cnt_reg == CW'(DIV - 1));
endmodule // acmc_div

// >>> logic/acmc_shift.sv
// Purpose: serial shift of a result on the data-out/ready pin
// Assumes: serial clock already synchronised, falling edges as pulses
// Notes:   msb first; pin shows ready level when not shifting
`timescale 1ns/1ps
`include "acmc_params.svh"
module acmc_shift
#(
   parameter int W = `ACMC_DATA_BITS
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic [W-1:0] data,
   input  wire logic         sclk_fall,
   input  wire logic         ready_n,
   output logic              dout,
   output logic              busy,
   output logic              last
);
   localparam int CW = $clog2(W + 1);
   logic [W-1:0]  sh_reg;
   logic [W-1:0]  sh_next;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          dout_reg;
   logic          dout_next;

   always_comb
   begin
      sh_next  = sh_reg;
      cnt_next = cnt_reg;
      last     = 1'b0;
      if (load)
      begin
         sh_next  = data;
         cnt_next = CW'(W);
      end
      else if (sclk_fall && cnt_reg != '0)
      begin
         sh_next  = {sh_reg[W-2:0], 1'b0};
         cnt_next = cnt_reg - CW'(1);
         last     = (cnt_reg == CW'(1));
      end
      dout_next = (cnt_next != '0) ? sh_next[W-1] : ready_n;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sh_reg   <= '0;
         cnt_reg  <= '0;
         dout_reg <= 1'b1;
      end
      else
      begin
         sh_reg   <= sh_next;
         cnt_reg  <= cnt_next;
         dout_reg <= dout_next;
      end
   end

   assign dout = dout_reg;
   assign busy = (cnt_reg != '0);
endmodule // acmc_shift

// >>> verif/acmc_asserts.sv
// Purpose: port-level checks of the conversion mode control block
// Assumes: zero-wait APB slave, one clock domain
// Notes:   shadow registers track what software last wrote
`timescale 1ns/1ps
`include "acmc_params.svh"
module acmc_asserts
(
   input  wire logic        CORE_CLK_IN,
   input  wire logic        RSTN_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   input  wire logic [31:0] PRDATA_OUT,
   input  wire logic        PREADY_OUT,
   input  wire logic        PSLVERR_OUT,
   input  wire logic        SCLK_IN,
   input  wire logic        DOUT_RDYN_OUT,
   input  wire logic        IRQ_OUT
);
   logic       acc;
   logic       wr;
   logic       rd;
   logic       mapped;
   logic [9:0] rate_reg;
   logic [9:0] rate_next;
   logic [2:0] order_reg;
   logic [2:0] order_next;
   logic [3:0] mode_reg;
   logic [3:0] mode_next;
   logic [1:0] mask_reg;
   logic [1:0] mask_next;
   ////////////////////////////////////////////////////////////////////
   assign acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
   assign wr = acc && PWRITE_IN;
   assign rd = acc && !PWRITE_IN;
   assign mapped = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN <= 8'h18);
   always_comb
   begin
      rate_next = rate_reg;
      order_next = order_reg;
      mode_next = mode_reg;
      mask_next = mask_reg;
      if (wr && PADDR_IN == `ACMC_ADDR_RATE && PWDATA_IN[9:0] != 10'h0)
         rate_next = PWDATA_IN[9:0];
      if (wr && PADDR_IN == `ACMC_ADDR_CTRL)
      begin
         mode_next = {PWDATA_IN[4], PWDATA_IN[2:0]};
         // an order of zero keeps the old order
         if (PWDATA_IN[10:8] != 3'h0)
            order_next = PWDATA_IN[10:8];
      end
      if (wr && PADDR_IN == `ACMC_ADDR_IRQ_MASK)
         mask_next = PWDATA_IN[1:0];
   end
   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         rate_reg <= `ACMC_RATE_RESET;
         order_reg <= `ACMC_ORDER_RESET;
         mode_reg <= 4'h0;
         mask_reg <= 2'h0;
      end
      else
      begin
         rate_reg <= rate_next;
         order_reg <= order_next;
         mode_reg <= mode_next;
         mask_reg <= mask_next;
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   sequence s_rd_status;
      rd && PADDR_IN == `ACMC_ADDR_STATUS;
   endsequence
   sequence s_rd_rate;
      rd && PADDR_IN == `ACMC_ADDR_RATE;
   endsequence
   a_pready_high: assert property (PREADY_OUT)
      else $error("pready low");
   a_err_unmapped: assert property (acc && !mapped |-> PSLVERR_OUT)
      else $error("no error on unmapped access");
   a_err_quiet: assert property (!(acc && !mapped) |-> !PSLVERR_OUT)
      else $error("error flag without unmapped access");
   a_rate_readback: assert property (
      s_rd_rate |-> PRDATA_OUT[9:0] == rate_reg)
      else $error("rate code readback wrong");
   a_order_readback: assert property (
      rd && PADDR_IN == `ACMC_ADDR_CTRL |-> PRDATA_OUT[10:8] == order_reg)
      else $error("filter order readback wrong");
   a_mode_readback: assert property (
      rd && PADDR_IN == `ACMC_ADDR_CTRL
      |-> {PRDATA_OUT[4], PRDATA_OUT[2:0]} == mode_reg)
      else $error("mode readback wrong");
   a_mask_readback: assert property (
      rd && PADDR_IN == `ACMC_ADDR_IRQ_MASK |-> PRDATA_OUT[1:0] == mask_reg)
      else $error("mask readback wrong");
   a_state_onehot: assert property (
      s_rd_status |-> $onehot(PRDATA_OUT[7:4]))
      else $error("state field not one-hot");
   a_irq_masked: assert property (
      mask_reg == 2'h0 && $past(mask_reg) == 2'h0 |-> !IRQ_OUT)
      else $error("interrupt while all masked");
endmodule // acmc_asserts

bind acmc_top acmc_asserts chk_u
(
   .CORE_CLK_IN(CORE_CLK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN),
   .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
   .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
   .PSLVERR_OUT(PSLVERR_OUT), .SCLK_IN(SCLK_IN),
   .DOUT_RDYN_OUT(DOUT_RDYN_OUT), .IRQ_OUT(IRQ_OUT)
);

// >>> verif/acmc_host_model.sv
// Purpose: serial host that clocks results off the data-out/ready pin
// Assumes: pin shifts on falling serial clock edges, msb first
// Notes:   clock stands high between frames; half period is per call
`timescale 1ns/1ps
module acmc_host_model
(
   input  wire logic clk,
   input  wire logic dout,
   output logic      sclk_out
);
   initial sclk_out = 1'b1;
   // sample late in the high phase so the pin has settled after sync
   task automatic shift(input int half, output logic [23:0] w);
      for (int i = 23; i >= 0; i--)
      begin
         repeat (half) @(posedge clk);
         w[i] = dout;
         sclk_out <= 1'b0;
         repeat (half) @(posedge clk);
         sclk_out <= 1'b1;
      end
   endtask
endmodule // acmc_host_model

// >>> verif/tb.sv
// Purpose: self-checking bench of the conversion mode control block
// Assumes: rate 1 and order 1 give a 1024-cycle window
// Notes:   serial host is a separate model
`timescale 1ns/1ps
module tb;
   logic        clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sclk;
   logic        dout;
   logic        irq;
   logic [31:0] q;
   logic        qe;
   logic [23:0] word;
   logic [23:0] dd;
   int          n_errors;
   int          total_checks;
   int          cyc;
   int          t0;
   int          t1;
   ////////////////////////////////////////////////////////////////////
   acmc_top #(.WAKE_CYCLES(10)) dut_u
   (
      .CORE_CLK_IN(clk), .RSTN_IN(rst_n), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .SCLK_IN(sclk), .DOUT_RDYN_OUT(dout),
      .IRQ_OUT(irq)
   );
   acmc_host_model host_u (.clk(clk), .dout(dout), .sclk_out(sclk));
   initial clk = 1'b0;
   always #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   ////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (n_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bail(input string nm);
      n_errors++;
      $display("ERROR %s expected done seen timeout", nm);
      report_and_stop();
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'h1 && n < 50);
      if (pready !== 1'h1)
         bail("pready");
      q = prdata;
      qe = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'h0, a, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic wait_for(input logic on_irq, input int lim);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while ((on_irq ? irq : ~dout) !== 1'h1 && n < lim);
      if ((on_irq ? irq : ~dout) !== 1'h1)
         bail("wait");
      t1 = cyc;
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(8'h04);
      chk("rate", 32'h60, {22'h0, q[9:0]});
      rd(8'h00);
      chk("order", 32'h4, {29'h0, q[10:8]});
      chk("mode", 32'h0, {29'h0, q[2:0]});
      rd(8'h08);
      chk("state", 32'h4, {28'h0, q[7:4]});
      wr(8'h04, 32'h0);
      rd(8'h04);
      chk("rate zero", 32'h60, {22'h0, q[9:0]});
      rd(8'h1C);
      chk("slverr", 32'h1, {31'h0, qe});
      wr(8'h04, 32'h1);
      rd(8'h04);
      chk("rate one", 32'h1, {22'h0, q[9:0]});
   endtask
   task automatic t_cont;
      wr(8'h00, 32'h100);
      t0 = cyc;
      wait_for(1'h0, 1200);
      chk("settle", 32'h1, {31'h0, (t1 - t0 >= 1000 && t1 - t0 <= 1100)});
      chk("irq off", 32'h0, {31'h0, irq});
      wr(8'h14, 32'h1);
      chk("irq on", 32'h1, {31'h0, irq});
      rd(8'h08);
      chk("ready bit", 32'h0, {31'h0, q[0]});
      chk("settled", 32'h1, {31'h0, q[3]});
      rd(8'h10);
      chk("done bit", 32'h1, {31'h0, q[0]});
      chk("irq clr", 32'h0, {31'h0, irq});
      rd(8'h0C);
      dd = q[23:0];
      @(posedge clk);
      chk("pin clr", 32'h1, {31'h0, dout});
      t0 = t1;
      wait_for(1'h0, 1200);
      chk("period", 32'd1024, t1 - t0);
      rd(8'h0C);
      chk("data", {8'h0, dd + 24'h1}, {8'h0, q[23:0]});
   endtask
   task automatic t_cmd;
      wait_for(1'h0, 1200);
      rd(8'h0C);
      dd = q[23:0];
      wr(8'h18, 32'h1);
      repeat (3) @(posedge clk);
      host_u.shift(12, word);
      chk("cmd word", {8'h0, dd}, {8'h0, word});
   endtask
   task automatic t_continuous_readout_enable;
      wr(8'h00, 32'h110);
      rd(8'h10);
      wait_for(1'h1, 1200);
      repeat (4) @(posedge clk);
      host_u.shift(6, word);
      repeat (8) @(posedge clk);
      chk("pin after", 32'h1, {31'h0, dout});
      rd(8'h0C);
      chk("continuous_readout_enable word", {8'h0, q[23:0]}, {8'h0, word});
   endtask
   task automatic t_single;
      wr(8'h14, 32'h2);
      rd(8'h10);
      wr(8'h00, 32'h101);
      t0 = cyc;
      wait_for(1'h1, 1400);
      chk("wake", 32'h1, {31'h0, (t1 - t0 >= 1019 && t1 - t0 <= 1040)});
      rd(8'h08);
      chk("power down", 32'h1, {28'h0, q[7:4]});
      chk("ready low", 32'h0, {31'h0, q[0]});
      repeat (1500) @(posedge clk);
      chk("ready held", 32'h0, {31'h0, dout});
      rd(8'h0C);
      @(posedge clk);
      chk("ready read", 32'h1, {31'h0, dout});
   endtask
   task automatic t_idle;
      wr(8'h00, 32'h102);
      wr(8'h14, 32'h3);
      rd(8'h10);
      repeat (1500) @(posedge clk);
      chk("idle pin", 32'h1, {31'h0, dout});
      chk("idle irq", 32'h0, {31'h0, irq});
      rd(8'h08);
      chk("idle state", 32'h1, {28'h0, q[7:4]});
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      cyc = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      t_regs();
      t_cont();
      t_cmd();
      t_continuous_readout_enable();
      t_single();
      t_idle();
      report_and_stop();
   end
endmodule // tb
